// ### pwmtif_chk_sva.sv
// Checker: port-level assertions for the input/status block
`timescale 1ns/1ps
module pwmtif_chk
	import pwmtif_pkg::*;
(
	// Clock, reset and bus controls
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pwrite,
	// Flag and fault sources
	input wire logic       trigger_a_event,
	input wire logic       cycle_end,
	input wire logic       fault_a_level,
	// Observed outputs
	input wire logic       irq_request,
	input wire logic       capture_b,
	input wire logic       fault_b_event,
	input wire logic [3:0] resp_a_mode,
	input wire logic       resp_a_active,
	input wire logic [3:0] resp_b_mode,
	input wire logic       resp_b_active
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// A request can only rise from a flag source or an enable write
	sequence s_irq_up;
		$rose(irq_request);
	endsequence
	sequence s_irq_src;
		fault_b_event || $past(trigger_a_event || cycle_end
			|| (psel && penable && pwrite));
	endsequence

	property p_irq_cause;
		s_irq_up |-> s_irq_src;
	endproperty
	property p_cap_pair;
		capture_b |-> fault_b_event;
	endproperty
	// An edge cannot be seen twice in a row
	property p_fault_pulse;
		fault_b_event |=> !fault_b_event;
	endproperty
	property p_resp_a_range;
		resp_a_mode <= 4'hA;
	endproperty
	property p_resp_b_range;
		resp_b_mode <= 4'hA;
	endproperty
	property p_resp_a_act;
		resp_a_active |-> resp_a_mode != 4'h0;
	endproperty
	property p_resp_b_act;
		resp_b_active |-> resp_b_mode != 4'h0;
	endproperty
	property p_resp_a_rise;
		$rose(resp_a_active) |-> $past(fault_a_level);
	endproperty

	a_irq_cause: assert property (p_irq_cause)
		else $error("irq without source");
	a_cap_pair: assert property (p_cap_pair)
		else $error("capture without fault");
	a_fault_pulse: assert property (p_fault_pulse)
		else $error("fault pulse too long");
	a_resp_a_range: assert property (p_resp_a_range)
		else $error("mode a out of range");
	a_resp_b_range: assert property (p_resp_b_range)
		else $error("mode b out of range");
	a_resp_a_act: assert property (p_resp_a_act)
		else $error("a active in mode zero");
	a_resp_b_act: assert property (p_resp_b_act)
		else $error("b active in mode zero");
	a_resp_a_rise: assert property (p_resp_a_rise)
		else $error("a active without fault");
endmodule

bind pwmtif_core pwmtif_chk u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite),
	.trigger_a_event(trigger_a_event), .cycle_end(cycle_end),
	.fault_a_level(fault_a_level), .irq_request(irq_request),
	.capture_b(capture_b), .fault_b_event(fault_b_event),
	.resp_a_mode(resp_a_mode), .resp_a_active(resp_a_active),
	.resp_b_mode(resp_b_mode), .resp_b_active(resp_b_active)
);

// ### pwmtif_core.sv
// Trigger input conditioning, interrupt flags, status and fault response
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

// Contract
// RQ1 - Filter option: output changes after four equal samples, delaying capture.
// RQ2 - Async option: event drives the waveform-stop path without synchronisation.
// RQ3 - Configuration zero disables filter and async path; others reserved.
// RQ4 - Polarity 0 triggers on falling/low, 1 on rising/high.
// RQ5 - Action 0 raises a fault only; 1 raises fault and capture.
// RQ6 - Trigger-event enable lets the event act as input B trigger.
// RQ7 - Enable bits 3 and 2 permit interrupts on trigger B and A.
// RQ8 - Enable bit 0 permits the cycle-end interrupt.
// RQ9 - Trigger-B flag sets on trigger or capture condition of input B.
// RQ10 - Trigger-A flag sets on trigger or capture condition of input A.
// RQ11 - Cycle-end flag sets whenever a timer cycle completes.
// RQ12 - Writing one clears a flag; only bits written with one clear.
// RQ13 - Activity bits 7 and 6 set on any level change of outputs B, A.
// RQ14 - Activity bit holds until software writes one to it.
// RQ15 - Command-ready high only once last command reached timer domain.
// RQ16 - Sync, restart, capture strobes or auto-update high write clear ready.
// RQ17 - Enable-ready set when synced; cleared by enable, disable, debug break; debug break clears it only while debug_run_control is low.
// RQ18 - Response mode zero takes no action.
// RQ19 - Modes 1 to 3 stop own output and handle opposite compare cycle.
// RQ20 - Modes 4 to 7 stop all outputs with their own continuation.
// RQ21 - Modes 8 to 0xA stop output on edge or level.
// RQ22 - Fault-only action applies the input's configured response mode.
// RQ23 - Response modes above 0xA behave like no action.
// RQ24 - Zero writes leave flags; hardware set beats simultaneous clear.
module pwmtif_core
	import pwmtif_pkg::*;
(
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// Event input B from the event system, asynchronous
	input  wire logic        event_b_in,
	// Input A conditions from the event-A logic, same clock
	input  wire logic        trigger_a_event,
	input  wire logic        fault_a_level,
	// Timer core, same clock
	input  wire logic        cycle_end,
	input  wire logic        waveform_output_a,
	input  wire logic        waveform_output_b,
	input  wire logic        command_synced,
	input  wire logic        enable_synced,
	// Command strobes seen by the synchroniser, same clock
	input  wire logic        sync_at_cycle_end_strobe,
	input  wire logic        sync_now_strobe,
	input  wire logic        restart_strobe,
	input  wire logic        soft_capture_a_strobe,
	input  wire logic        soft_capture_b_strobe,
	input  wire logic        compare_b_clear_high_byte,
	input  wire logic        auto_update,
	input  wire logic        enable_write,
	input  wire logic        disable_at_cycle_end_strobe,
	input  wire logic        debug_break,
	input  wire logic        debug_run_control,
	// Interrupt request towards the interrupt controller
	output logic             irq_request,
	// Input B event results
	output logic             capture_b,
	output logic             fault_b_event,
	output logic             fault_b_level,
	output logic             fault_b_async,
	// Fault responses for inputs A and B
	output logic [3:0]       resp_a_mode,
	output logic             resp_a_active,
	output logic [3:0]       resp_b_mode,
	output logic             resp_b_active
);

	// Register storage
	logic [7:0] event_b_control;
	logic [7:0] interrupt_enable;
	logic [7:0] interrupt_pending;
	logic       output_b_activity;
	logic       output_a_activity;
	logic       command_ready;
	logic       enable_ready;
	logic [7:0] input_a_response;
	logic [7:0] input_b_response;

	// Bus decode
	logic [9:0] word_index;
	logic       bus_write;
	logic       bus_setup_read;
	logic       hit_evb;
	logic       hit_ien;
	logic       hit_ipend;
	logic       hit_stat;
	logic       hit_ina;
	logic       hit_inb;
	logic       addr_mapped;
	logic [7:0] wbyte;
	logic [7:0] next_rdata;

	// Event B conditioning
	logic       event_b_meta;
	logic       event_b_sync;
	logic [FILTER_SAMPLES-2:0] event_b_hist;
	logic       event_b_filtered;
	logic       event_b_cond;
	logic       event_b_prev;
	logic [1:0] cfg_b;
	logic       polarity_b;
	logic       action_capture;
	logic       trig_enable_b;
	logic       active_level_b;
	logic       active_edge_b;

	// Activity edge detect
	logic       wave_a_prev;
	logic       wave_b_prev;

	// Fault response sanitising
	pwmtif_resp_t next_mode_a;
	pwmtif_resp_t next_mode_b;

	// Command-ready and enable-ready clear sources
	logic       command_issue;
	logic       enable_clear;

	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~addr_mapped;

	assign word_index     = paddr[11:ADDR_SHIFT];
	assign bus_write      = psel & penable & pwrite;
	assign bus_setup_read = psel & ~penable & ~pwrite;
	assign wbyte          = pwdata[7:0];

	// Address decode on word index
	always_comb begin
		hit_evb   = 1'b0;
		hit_ien   = 1'b0;
		hit_ipend = 1'b0;
		hit_stat  = 1'b0;
		hit_ina   = 1'b0;
		hit_inb   = 1'b0;
		if (word_index == {2'h0, IDX_EVENT_B_CONTROL}) begin
			hit_evb = 1'b1;
		end else if (word_index == {2'h0, IDX_INTERRUPT_ENABLE}) begin
			hit_ien = 1'b1;
		end else if (word_index == {2'h0, IDX_INTERRUPT_PENDING}) begin
			hit_ipend = 1'b1;
		end else if (word_index == {2'h0, IDX_SYNC_ACTIVITY}) begin
			hit_stat = 1'b1;
		end else if (word_index == {2'h0, IDX_INPUT_A_RESPONSE}) begin
			hit_ina = 1'b1;
		end else if (word_index == {2'h0, IDX_INPUT_B_RESPONSE}) begin
			hit_inb = 1'b1;
		end
		addr_mapped = hit_evb | hit_ien | hit_ipend | hit_stat
			| hit_ina | hit_inb;
	end

	// Read mux; unmapped words read as zero
	always_comb begin
		next_rdata = 8'h00;
		if (hit_evb) begin
			next_rdata = event_b_control;
		end else if (hit_ien) begin
			next_rdata = interrupt_enable;
		end else if (hit_ipend) begin
			next_rdata = interrupt_pending;
		end else if (hit_stat) begin
			next_rdata = {output_b_activity, output_a_activity, 4'h0,
				command_ready, enable_ready};
		end else if (hit_ina) begin
			next_rdata = input_a_response;
		end else if (hit_inb) begin
			next_rdata = input_b_response;
		end
	end

	// Read data captured in the setup cycle so it is a flop in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (bus_setup_read) begin
			prdata <= {24'h00_0000, next_rdata};
		end
	end

	// Event B control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_b_control <= RST_EVENT_B_CONTROL;
		end else if (bus_write && hit_evb) begin
			event_b_control <= wbyte & MASK_EVENT_B_CONTROL;
		end
	end

	// Interrupt enable register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_enable <= RST_INTERRUPT_ENABLE;
		end else if (bus_write && hit_ien) begin
			interrupt_enable <= wbyte & MASK_INTERRUPT; // [RQ7] [RQ8]
		end
	end

	// Response mode registers for both inputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			input_a_response <= RST_INPUT_RESPONSE;
			input_b_response <= RST_INPUT_RESPONSE;
		end else if (bus_write) begin
			if (hit_ina) begin
				input_a_response <= wbyte & MASK_INPUT_RESPONSE;
			end
			if (hit_inb) begin
				input_b_response <= wbyte & MASK_INPUT_RESPONSE;
			end
		end
	end

	assign cfg_b          = event_b_control[EVB_CFG_HI:EVB_CFG_LO];
	assign polarity_b     = event_b_control[EVB_POLARITY];
	assign action_capture = event_b_control[EVB_ACTION];
	assign trig_enable_b  = event_b_control[EVB_TRIG_ENABLE];

	// Two-flop synchroniser; only the second flop feeds logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_b_meta <= 1'b0;
			event_b_sync <= 1'b0;
		end else begin
			event_b_meta <= event_b_in;
			event_b_sync <= event_b_meta;
		end
	end

	// Noise filter: live sample plus history must agree, so delay is four
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_b_hist     <= '0;
			event_b_filtered <= 1'b0;
		end else begin
			event_b_hist <= {event_b_hist[FILTER_SAMPLES-3:0],
				event_b_sync};
			if (&{event_b_hist, event_b_sync}) begin
				event_b_filtered <= 1'b1; // [RQ1]
			end else if (~|{event_b_hist, event_b_sync}) begin
				event_b_filtered <= 1'b0; // [RQ1]
			end
		end
	end

	// Reserved codes fall back to the plain synchronised path
	always_comb begin
		if (cfg_b == CFG_NOISE_FILTER) begin
			event_b_cond = event_b_filtered; // [RQ1]
		end else begin
			event_b_cond = event_b_sync; // [RQ3]
		end
	end

	// Active level and edge per polarity
	assign active_level_b = trig_enable_b
		& (event_b_cond == polarity_b); // [RQ4] [RQ6]
	assign active_edge_b  = trig_enable_b & (event_b_cond != event_b_prev)
		& (event_b_cond == polarity_b); // [RQ4] [RQ6]

	// Unsynchronised stop request; it bypasses the flops on purpose
	// so an output can be stopped even when the clock is slow
	assign fault_b_async = trig_enable_b && (cfg_b == CFG_ASYNC_PATH)
		&& (event_b_in == polarity_b); // [RQ2]

	// Edge history and registered event outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			event_b_prev  <= 1'b0;
			fault_b_event <= 1'b0;
			fault_b_level <= 1'b0;
			capture_b     <= 1'b0;
		end else begin
			event_b_prev  <= event_b_cond;
			fault_b_event <= active_edge_b; // [RQ5] [RQ22]
			fault_b_level <= active_level_b;
			capture_b     <= active_edge_b & action_capture; // [RQ5]
		end
	end

	// Interrupt flags; hardware set wins over a write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			interrupt_pending <= 8'h00;
		end else begin
			if (bus_write && hit_ipend) begin
				interrupt_pending <= interrupt_pending
					& ~(wbyte & MASK_INTERRUPT); // [RQ12] [RQ24]
			end
			if (active_edge_b) begin
				interrupt_pending[INT_TRIG_B] <= 1'b1; // [RQ9] [RQ24]
			end
			if (trigger_a_event) begin
				interrupt_pending[INT_TRIG_A] <= 1'b1; // [RQ10] [RQ24]
			end
			if (cycle_end) begin
				interrupt_pending[INT_CYCLE_END] <= 1'b1; // [RQ11] [RQ24]
			end
		end
	end

	// Request raised while any enabled flag is pending
	assign irq_request = |(interrupt_pending & interrupt_enable); // [RQ7] [RQ8]

	// Previous output levels for toggle detection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wave_a_prev <= 1'b0;
			wave_b_prev <= 1'b0;
		end else begin
			wave_a_prev <= waveform_output_a;
			wave_b_prev <= waveform_output_b;
		end
	end

	// Activity bits stick until software writes one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_a_activity <= 1'b0;
			output_b_activity <= 1'b0;
		end else begin
			if (waveform_output_a != wave_a_prev) begin
				output_a_activity <= 1'b1; // [RQ13] [RQ24]
			end else if (bus_write && hit_stat && wbyte[ST_ACT_A]) begin
				output_a_activity <= 1'b0; // [RQ14]
			end
			if (waveform_output_b != wave_b_prev) begin
				output_b_activity <= 1'b1; // [RQ13] [RQ24]
			end else if (bus_write && hit_stat && wbyte[ST_ACT_B]) begin
				output_b_activity <= 1'b0; // [RQ14]
			end
		end
	end

	assign command_issue = sync_at_cycle_end_strobe | sync_now_strobe
		| restart_strobe | soft_capture_a_strobe | soft_capture_b_strobe
		| (compare_b_clear_high_byte & auto_update); // [RQ16]
	assign enable_clear  = enable_write | disable_at_cycle_end_strobe
		| (debug_break & ~debug_run_control); // [RQ17]

	// Ready bits; a new command outranks the end of the previous one,
	// since reporting ready would let software overrun the sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			command_ready <= 1'b0;
			enable_ready  <= 1'b0;
		end else begin
			if (command_issue) begin
				command_ready <= 1'b0; // [RQ16]
			end else if (command_synced) begin
				command_ready <= 1'b1; // [RQ15]
			end
			if (enable_clear) begin
				enable_ready <= 1'b0; // [RQ17]
			end else if (enable_synced) begin
				enable_ready <= 1'b1; // [RQ17]
			end
		end
	end

	// Undefined response codes map to no action
	always_comb begin
		if (input_a_response[3:0] > RESP_LEVEL_STOP_KEEP_PER) begin
			next_mode_a = RESP_NONE; // [RQ23]
		end else begin
			next_mode_a = pwmtif_resp_t'(input_a_response[3:0]);
		end
		if (input_b_response[3:0] > RESP_LEVEL_STOP_KEEP_PER) begin
			next_mode_b = RESP_NONE; // [RQ23]
		end else begin
			next_mode_b = pwmtif_resp_t'(input_b_response[3:0]);
		end
	end

	// Response to the core: mode and whether a fault is acting now;
	// mode zero never asserts active, so outputs stay untouched
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_a_mode   <= RESP_NONE;
			resp_a_active <= 1'b0;
			resp_b_mode   <= RESP_NONE;
			resp_b_active <= 1'b0;
		end else begin
			resp_a_mode   <= next_mode_a; // [RQ19] [RQ20] [RQ21]
			resp_a_active <= (next_mode_a != RESP_NONE)
				& fault_a_level; // [RQ18]
			resp_b_mode   <= next_mode_b; // [RQ22]
			resp_b_active <= (next_mode_b != RESP_NONE)
				& active_level_b; // [RQ18] [RQ22]
		end
	end

endmodule

// ### pwmtif_evsrc.sv
// Event source model driving trigger input B
`timescale 1ns/1ps
module pwmtif_evsrc (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Requested level and one-cycle glitch order
	input wire logic level_req,
	input wire logic glitch_req,
	// Event line towards the block
	output logic     event_b_in
);
	// Glitch shows the inverse level for one cycle, to test the filter
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			event_b_in <= 1'b0;
		else
			event_b_in <= glitch_req ? ~level_req : level_req;
	end
endmodule

// ### pwmtif_pkg.sv
// Package: register map, field layout and reset values of the input/status block
package pwmtif_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_EVENT_B_CONTROL   = 8'h09;
	localparam logic [7:0] IDX_INTERRUPT_ENABLE  = 8'h0C;
	localparam logic [7:0] IDX_INTERRUPT_PENDING = 8'h0D;
	localparam logic [7:0] IDX_SYNC_ACTIVITY     = 8'h0E;
	localparam logic [7:0] IDX_INPUT_A_RESPONSE  = 8'h10;
	localparam logic [7:0] IDX_INPUT_B_RESPONSE  = 8'h11;
	localparam int         ADDR_SHIFT            = 2;

	// Reset values
	localparam logic [7:0] RST_EVENT_B_CONTROL   = 8'h00;
	localparam logic [7:0] RST_INTERRUPT_ENABLE  = 8'h00;
	localparam logic [7:0] RST_INPUT_RESPONSE    = 8'h00;

	// Writable bit masks
	localparam logic [7:0] MASK_EVENT_B_CONTROL  = 8'hD5;
	localparam logic [7:0] MASK_INTERRUPT        = 8'h0D;
	localparam logic [7:0] MASK_INPUT_RESPONSE   = 8'h0F;

	// Event control field positions
	localparam int EVB_CFG_HI       = 7;
	localparam int EVB_CFG_LO       = 6;
	localparam int EVB_POLARITY     = 4;
	localparam int EVB_ACTION       = 2;
	localparam int EVB_TRIG_ENABLE  = 0;

	// Interrupt and status field positions
	localparam int INT_TRIG_B       = 3;
	localparam int INT_TRIG_A       = 2;
	localparam int INT_CYCLE_END    = 0;
	localparam int ST_ACT_B         = 7;
	localparam int ST_ACT_A         = 6;
	localparam int ST_CMD_READY     = 1;
	localparam int ST_EN_READY      = 0;

	// Event configuration encodings
	localparam logic [1:0] CFG_NEITHER          = 2'h0;
	localparam logic [1:0] CFG_NOISE_FILTER     = 2'h1;
	localparam logic [1:0] CFG_ASYNC_PATH       = 2'h2;

	// Filter needs this many equal samples before its output moves
	localparam int FILTER_SAMPLES = 4;

	// Fault response encodings
	typedef enum logic [3:0] {
		RESP_NONE                 = 4'h0,
		RESP_JUMP_OPPOSITE_WAIT   = 4'h1,
		RESP_RUN_OPPOSITE_WAIT    = 4'h2,
		RESP_RUN_OPPOSITE_ACTIVE  = 4'h3,
		RESP_STOP_ALL_KEEP_PERIOD = 4'h4,
		RESP_STOP_ALL_DEAD_TIME   = 4'h5,
		RESP_STOP_ALL_NEXT_WAIT   = 4'h6,
		RESP_STOP_ALL_SW_WAIT     = 4'h7,
		RESP_EDGE_STOP_NEXT_CYCLE = 4'h8,
		RESP_EDGE_STOP_KEEP_PER   = 4'h9,
		RESP_LEVEL_STOP_KEEP_PER  = 4'hA
	} pwmtif_resp_t;

endpackage

// ### testbench.sv
// Testbench: random and corner stimulus for the input/status block
`timescale 1ns/1ps
module testbench
	import pwmtif_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, r;
	logic        trigger_a_event, fault_a_level, cycle_end, wave_a, wave_b;
	logic        command_synced, enable_synced, auto_update, dbg_run;
	logic [8:0]  strb;
	logic        level_req, glitch_req, event_b_in, err, cap, asy;
	logic        irq_request, capture_b, fault_b_event, fault_b_level;
	logic        fault_b_async, resp_a_active, resp_b_active;
	logic [3:0]  resp_a_mode, resp_b_mode;
	logic [7:0]  e;
	int          fail_count, checked, seed, n;
	localparam logic [7:0] idx_t [4] = '{IDX_EVENT_B_CONTROL,
		IDX_INTERRUPT_ENABLE, IDX_INPUT_A_RESPONSE, IDX_INPUT_B_RESPONSE};
	localparam logic [7:0] mask_t [4] = '{MASK_EVENT_B_CONTROL,
		MASK_INTERRUPT, MASK_INPUT_RESPONSE, MASK_INPUT_RESPONSE};
	// Negedges to the pulse: one per flop (partner, two sync, output) plus 1
	localparam int lat_plain = 5;

	pwmtif_core u_pwmtif_core (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pready(pready), .prdata(prdata), .pslverr(pslverr),
		.event_b_in(event_b_in), .trigger_a_event(trigger_a_event),
		.fault_a_level(fault_a_level), .cycle_end(cycle_end),
		.waveform_output_a(wave_a), .waveform_output_b(wave_b),
		.command_synced(command_synced), .enable_synced(enable_synced),
		.sync_at_cycle_end_strobe(strb[0]), .sync_now_strobe(strb[1]),
		.restart_strobe(strb[2]), .soft_capture_a_strobe(strb[3]),
		.soft_capture_b_strobe(strb[4]),
		.compare_b_clear_high_byte(strb[5]), .auto_update(auto_update),
		.enable_write(strb[6]), .disable_at_cycle_end_strobe(strb[7]),
		.debug_break(strb[8]), .debug_run_control(dbg_run),
		.irq_request(irq_request), .capture_b(capture_b),
		.fault_b_event(fault_b_event), .fault_b_level(fault_b_level),
		.fault_b_async(fault_b_async), .resp_a_mode(resp_a_mode),
		.resp_a_active(resp_a_active), .resp_b_mode(resp_b_mode),
		.resp_b_active(resp_b_active)
	);
	pwmtif_evsrc u_pwmtif_evsrc (.pclk(pclk), .presetn(presetn),
		.level_req(level_req), .glitch_req(glitch_req),
		.event_b_in(event_b_in));

	// 100 ns period
	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, exp, input string msg);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask

	// One APB transfer; holds the request until pready is sampled
	task automatic apb(input logic wr, input logic [7:0] idx,
		input logic [31:0] wd);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'h0, idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (pready !== 1'b1)
			fail_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, {24'h0, d});
	endtask

	task automatic rdx(input logic [7:0] idx, exp, input string msg);
		apb(1'b0, idx, 32'h0);
		chk(rd, {24'h0, exp}, msg);
	endtask

	// Moves the event line and counts cycles to the fault pulse
	task automatic lat(input logic v);
		@(posedge pclk);
		level_req <= v;
		n = 0;
		for (int i = 1; i <= 12 && n == 0; i++) begin
			@(negedge pclk);
			if (i == 2)
				asy = fault_b_async;
			if (fault_b_event === 1'b1) begin
				n = i;
				cap = capture_b;
			end
		end
	endtask

	task automatic stop_test;
		if (fail_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog, far beyond the expected few hundred cycles
	initial begin
		#2000000;
		fail_count++;
		stop_test();
	end

	initial begin
		seed = 41;
		fail_count = 0;
		checked = 0;
		{psel, penable, pwrite, trigger_a_event, fault_a_level} = '0;
		{cycle_end, wave_a, wave_b, command_synced, enable_synced} = '0;
		{auto_update, dbg_run, level_req, glitch_req} = '0;
		paddr = '0;
		pwdata = '0;
		strb = '0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (int k = 0; k < 4; k++)
			rdx(idx_t[k], 8'h00, "reset value");
		rdx(IDX_SYNC_ACTIVITY, 8'h00, "status reset");
		apb(1'b0, 8'h00, 32'h0);
		chk(err, 1'b1, "unmapped");
		for (int k = 0; k < 4; k++) begin
			r = $random(seed);
			wr(idx_t[k], r[7:0]);
			rdx(idx_t[k], r[7:0] & mask_t[k], "read back");
			wr(idx_t[k], 8'h00);
		end
		wr(IDX_INTERRUPT_PENDING, 8'h0D);
		// Rising edge, capture enabled, no filter
		wr(IDX_EVENT_B_CONTROL, 8'h15);
		lat(1'b1);
		chk(n, lat_plain, "latency");
		chk(cap, 1'b1, "capture");
		chk(asy, 1'b0, "async off");
		rdx(IDX_INTERRUPT_PENDING, 8'h08, "flag b");
		wr(IDX_INTERRUPT_ENABLE, 8'h0D);
		@(negedge pclk);
		chk(irq_request, 1'b1, "irq b");
		wr(IDX_INTERRUPT_PENDING, 8'h00);
		rdx(IDX_INTERRUPT_PENDING, 8'h08, "zero write");
		wr(IDX_INTERRUPT_PENDING, 8'h08);
		@(negedge pclk);
		chk(irq_request, 1'b0, "irq clear");
		// Falling edge, fault only
		wr(IDX_EVENT_B_CONTROL, 8'h01);
		lat(1'b0);
		chk(n, lat_plain, "falling");
		chk(cap, 1'b0, "fault only");
		wr(IDX_EVENT_B_CONTROL, 8'h10);
		lat(1'b1);
		chk(n, 0, "disabled");
		// Filter: a one-cycle glitch must vanish
		wr(IDX_EVENT_B_CONTROL, 8'h55);
		lat(1'b0);
		chk(n, 0, "inactive edge");
		@(posedge pclk);
		glitch_req <= 1'b1;
		@(posedge pclk);
		glitch_req <= 1'b0;
		lat(1'b0);
		chk(n, 0, "glitch");
		lat(1'b1);
		chk(n, lat_plain + FILTER_SAMPLES, "filtered");
		wr(IDX_EVENT_B_CONTROL, 8'h91);
		lat(1'b0);
		lat(1'b1);
		chk(asy, 1'b1, "async");
		wr(IDX_EVENT_B_CONTROL, 8'hD1);
		lat(1'b0);
		lat(1'b1);
		chk(n, lat_plain, "reserved cfg");
		chk(asy, 1'b0, "reserved async");
		wr(IDX_INTERRUPT_PENDING, 8'h0D);
		@(posedge pclk);
		cycle_end <= 1'b1;
		trigger_a_event <= 1'b1;
		@(posedge pclk);
		cycle_end <= 1'b0;
		trigger_a_event <= 1'b0;
		rdx(IDX_INTERRUPT_PENDING, 8'h05, "flags a, end");
		chk(irq_request, 1'b1, "irq end");
		wr(IDX_INTERRUPT_PENDING, 8'h05);
		rdx(IDX_INTERRUPT_PENDING, 8'h00, "cleared");
		// Output activity, both directions
		@(posedge pclk);
		wave_a <= 1'b1;
		rdx(IDX_SYNC_ACTIVITY, 8'h40, "act a");
		@(posedge pclk);
		wave_b <= 1'b1;
		@(posedge pclk);
		wave_b <= 1'b0;
		rdx(IDX_SYNC_ACTIVITY, 8'hC0, "act b");
		wr(IDX_SYNC_ACTIVITY, 8'h40);
		rdx(IDX_SYNC_ACTIVITY, 8'h80, "act clear");
		wr(IDX_SYNC_ACTIVITY, 8'h80);
		// Each clear source in turn, plus two that must not clear
		for (int i = 0; i < 11; i++) begin
			@(posedge pclk);
			command_synced <= 1'b1;
			enable_synced <= 1'b1;
			auto_update <= (i != 9);
			dbg_run <= (i == 10);
			@(posedge pclk);
			command_synced <= 1'b0;
			enable_synced <= 1'b0;
			rdx(IDX_SYNC_ACTIVITY, 8'h03, "ready");
			@(posedge pclk);
			strb <= 9'h1 << (i == 9 ? 5 : i == 10 ? 8 : i);
			@(posedge pclk);
			strb <= '0;
			e = (i > 8) ? 8'h03 : (i < 6) ? 8'h01 : 8'h02;
			rdx(IDX_SYNC_ACTIVITY, e, "ready clear");
		end
		// Every response code on input A, fault level at random
		for (int m = 0; m < 16; m++) begin
			r = $random(seed);
			wr(IDX_INPUT_A_RESPONSE, {r[7:4], m[3:0]});
			@(posedge pclk);
			fault_a_level <= r[8];
			repeat (3) @(negedge pclk);
			e = (m > 10) ? 8'h00 : 8'(m);
			chk(resp_a_mode, e[3:0], "mode a");
			chk(resp_a_active, r[8] && e != 0, "act a");
		end
		@(posedge pclk);
		fault_a_level <= 1'b0;
		wr(IDX_EVENT_B_CONTROL, 8'h11);
		wr(IDX_INPUT_B_RESPONSE, 8'h05);
		repeat (3) @(negedge pclk);
		chk(fault_b_level, 1'b1, "level b");
		chk(resp_b_mode, 4'h5, "mode b");
		chk(resp_b_active, 1'b1, "act b");
		lat(1'b0);
		chk(resp_b_active, 1'b0, "b released");
		stop_test();
	end
endmodule
